/* File: hdl/dbc_pkg.sv */
// Purpose: shared constants and types of the bridge clock and receiver config bank
// Assumes: byte-wide registers reached over the two-wire serial port
// Notes: reset values follow the field defaults of each register
package dbc_pkg;
	// ------------------------------------------------------------
	// register offsets (sub-addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_OUT_CLOCK_SOURCE = 8'h0A;
	localparam logic [7:0] OFS_OUT_CLOCK_SCALE = 8'h0B;
	localparam logic [7:0] OFS_SYNTH_LOOP = 8'h0D;
	localparam logic [7:0] OFS_RX_ARRANGE = 8'h10;
	localparam logic [7:0] OFS_RX_EQUALIZE = 8'h11;
	localparam logic [7:0] OFS_RX_A_BAND = 8'h12;
	localparam logic [7:0] OFS_RX_B_BAND = 8'h13;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int POS_SRC_SEL = 0;
	localparam int POS_OUT_RANGE = 1;
	localparam int POS_DIV_CODE = 3;
	localparam int POS_MULT_CODE = 0;
	localparam int POS_PLL_EN = 0;
	localparam int POS_SPLIT = 7;
	localparam int POS_CH_MODE = 5;
	localparam int POS_LANE_A = 3;
	localparam int POS_LANE_B = 1;
	localparam int POS_STRICT = 0;
	localparam int POS_EQ_A_DATA = 6;
	localparam int POS_EQ_B_DATA = 4;
	localparam int POS_EQ_A_CLK = 2;
	localparam int POS_EQ_B_CLK = 0;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [2:0] RST_OUT_RANGE = 3'h5;
	localparam logic [1:0] RST_CH_MODE = 2'h1;
	localparam logic [1:0] RST_LANES = 2'h3;
	localparam logic [4:0] RST_DIV_CODE = 5'h00;
	localparam logic [1:0] RST_MULT_CODE = 2'h0;
	localparam logic [1:0] RST_EQ = 2'h0;
	localparam logic [7:0] RST_BAND = 8'h00;
	// ------------------------------------------------------------
	// serial port constants and the receiver lane mask
	// ------------------------------------------------------------
	localparam logic [5:0] DEV_ADDR_HI = 6'h16;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] FULL_LANE_MASK = 4'hF;
	// all read/write configuration fields
	typedef struct packed {
		logic [2:0] out_range;
		logic pixel_clock_source_select;
		logic [4:0] div_code;
		logic [1:0] ref_input_scale_code;
		logic pll_enable;
		logic pixel_split_lr;
		logic [1:0] channel_mode;
		logic [1:0] rx_a_lane_count;
		logic [1:0] rx_b_lane_count;
		logic leader_error_strict;
		logic [1:0] rx_a_data_equalize;
		logic [1:0] rx_b_data_equalize;
		logic [1:0] rx_a_clock_equalize;
		logic [1:0] rx_b_clock_equalize;
		logic [7:0] rx_a_clock_band;
		logic [7:0] rx_b_clock_band;
	} dbc_csr_t;
endpackage

/* File: hdl/dbc_cfg_regs.sv */
// What this block does
// - with channel A clock as source, output clock divides by code plus one.
// - with reference source, multiplier code 00..11 scales by one to four.
// - synthesizer enable bit starts the loop with current settings; reset clears it.
// - split bit selects odd/even or left/right pixels between the channels.
// - channel mode field picks dual, single or two independent receivers.
// - channel A lane code 00..11 enables four down to one lane.
// - channel B lane code uses the same coding, one lane after reset.
// - strict bit clear tolerates one leader bit error; set rejects any.
// - four equalizer fields encode none, 1 dB, 2 dB; 10 reserved.
// - source select bit picks reference input at 0, channel A clock at 1.
// - each written byte is acknowledged and stored at the current sub-address, which then advances; bytes to holes are dropped.
//
// Purpose: two-wire serial slave with the clock and receiver configuration bank
// Assumes: serial pins oversampled by the 50 MHz reference clock
// Notes: the serial data pin is open drain, driven low only
`timescale 1ns/1ps
module dbc_cfg_regs
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_addr_sel,
	output logic o_sda_out,
	output logic o_sda_oe,
	output dbc_pkg::dbc_csr_t o_cfg,
	output logic [5:0] o_div_ratio,
	output logic [2:0] o_mult_factor,
	output logic [7:0] o_rx_lane_en
);
	// ------------------------------------------------------------
	// pin synchronisers and edge detection
	// ------------------------------------------------------------
	logic [2:0] scl_pipe_r;
	logic [2:0] sda_pipe_r;
	logic [1:0] addr_pipe_r;
	logic scl_s, scl_d, sda_s, sda_d;
	logic scl_rise, scl_fall, start_cond, stop_cond;

	// stage 0 feeds only stage 1; detectors look at stages 1 and 2
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			scl_pipe_r <= 3'h7;
			sda_pipe_r <= 3'h7;
			addr_pipe_r <= 2'h0;
		end
		else
		begin
			scl_pipe_r <= {scl_pipe_r[1:0], i_scl};
			sda_pipe_r <= {sda_pipe_r[1:0], i_sda};
			addr_pipe_r <= {addr_pipe_r[0], i_addr_sel};
		end
	end

	// bus events seen on the synchronised levels
	assign scl_s = scl_pipe_r[1];
	assign scl_d = scl_pipe_r[2];
	assign sda_s = sda_pipe_r[1];
	assign sda_d = sda_pipe_r[2];
	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;

	// ------------------------------------------------------------
	// serial protocol state machine
	// ------------------------------------------------------------
	typedef enum logic [4:0]
	{
		ST_IDLE = 5'b00001,
		ST_RECV = 5'b00010,
		ST_ACK = 5'b00100,
		ST_SEND = 5'b01000,
		ST_RACK = 5'b10000
	} dbc_state_t;
	typedef enum logic [2:0]
	{
		PH_DEV = 3'b001,
		PH_SUB = 3'b010,
		PH_DATA = 3'b100
	} dbc_phase_t;

	dbc_state_t st_r, st_nxt;
	dbc_phase_t phase_r, phase_nxt;
	logic [3:0] bitcnt_r, bitcnt_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [7:0] ptr_r, ptr_nxt;
	logic rw_r, rw_nxt;
	logic sda_oe_r, sda_oe_nxt;
	logic wr_en;
	logic [7:0] rd_byte;
	dbc_pkg::dbc_csr_t csr_r, csr_nxt;

	// read mux; holes and unused bits read zero
	always_comb
	begin
		rd_byte = 8'h00;
		// read back of every field
		// stored value readback
		unique case (ptr_r)
			dbc_pkg::OFS_OUT_CLOCK_SOURCE:
			begin
				rd_byte[dbc_pkg::POS_OUT_RANGE +: 3] = csr_r.out_range;
				rd_byte[dbc_pkg::POS_SRC_SEL] = csr_r.pixel_clock_source_select;
			end
			dbc_pkg::OFS_OUT_CLOCK_SCALE:
			begin
				rd_byte[dbc_pkg::POS_DIV_CODE +: 5] = csr_r.div_code;
				rd_byte[dbc_pkg::POS_MULT_CODE +: 2] = csr_r.ref_input_scale_code;
			end
			dbc_pkg::OFS_SYNTH_LOOP:
				rd_byte[dbc_pkg::POS_PLL_EN] = csr_r.pll_enable;
			dbc_pkg::OFS_RX_ARRANGE:
			begin
				rd_byte[dbc_pkg::POS_SPLIT] = csr_r.pixel_split_lr;
				rd_byte[dbc_pkg::POS_CH_MODE +: 2] = csr_r.channel_mode;
				rd_byte[dbc_pkg::POS_LANE_A +: 2] = csr_r.rx_a_lane_count;
				rd_byte[dbc_pkg::POS_LANE_B +: 2] = csr_r.rx_b_lane_count;
				rd_byte[dbc_pkg::POS_STRICT] = csr_r.leader_error_strict;
			end
			dbc_pkg::OFS_RX_EQUALIZE:
			begin
				rd_byte[dbc_pkg::POS_EQ_A_DATA +: 2] = csr_r.rx_a_data_equalize;
				rd_byte[dbc_pkg::POS_EQ_B_DATA +: 2] = csr_r.rx_b_data_equalize;
				rd_byte[dbc_pkg::POS_EQ_A_CLK +: 2] = csr_r.rx_a_clock_equalize;
				rd_byte[dbc_pkg::POS_EQ_B_CLK +: 2] = csr_r.rx_b_clock_equalize;
			end
			dbc_pkg::OFS_RX_A_BAND:
				rd_byte = csr_r.rx_a_clock_band;
			dbc_pkg::OFS_RX_B_BAND:
				rd_byte = csr_r.rx_b_clock_band;
			default:
				rd_byte = 8'h00;
		endcase
	end

	// next state of the serial slave; stop and start override any state
	always_comb
	begin
		st_nxt = st_r;
		phase_nxt = phase_r;
		bitcnt_nxt = bitcnt_r;
		shift_nxt = shift_r;
		ptr_nxt = ptr_r;
		rw_nxt = rw_r;
		sda_oe_nxt = sda_oe_r;
		wr_en = 1'b0;
		if (stop_cond)
		begin
			st_nxt = ST_IDLE;
			sda_oe_nxt = 1'b0;
		end
		else if (start_cond)
		begin
			st_nxt = ST_RECV;
			phase_nxt = PH_DEV;
			bitcnt_nxt = 4'h0;
			sda_oe_nxt = 1'b0;
		end
		else
		begin
			unique case (st_r)
				ST_IDLE:
					st_nxt = ST_IDLE;
				ST_RECV:
				begin
					if (scl_rise)
					begin
						shift_nxt = {shift_r[6:0], sda_s};
						bitcnt_nxt = bitcnt_r + 4'h1;
					end
					else if (scl_fall && bitcnt_r == dbc_pkg::BITS_PER_BYTE)
					begin
						bitcnt_nxt = 4'h0;
						st_nxt = ST_ACK;
						sda_oe_nxt = 1'b1;
						unique case (phase_r)
							PH_DEV:
							begin
								rw_nxt = shift_r[0];
								// foreign address: stay off the bus
								if (shift_r[7:1] != {dbc_pkg::DEV_ADDR_HI, addr_pipe_r[1]})
								begin
									st_nxt = ST_IDLE;
									sda_oe_nxt = 1'b0;
								end
							end
							PH_SUB:
								ptr_nxt = shift_r;
							PH_DATA:
							begin
								wr_en = 1'b1;
								ptr_nxt = ptr_r + 8'h01;
							end
						endcase
					end
				end
				ST_ACK:
				begin
					if (scl_fall)
					begin
						sda_oe_nxt = 1'b0;
						if (rw_r)
						begin
							// reads start at the current sub-address pointer: the last sub-address sent, advanced by each byte written or read since
							st_nxt = ST_SEND;
							shift_nxt = rd_byte;
							ptr_nxt = ptr_r + 8'h01;
							sda_oe_nxt = ~rd_byte[7];
							bitcnt_nxt = 4'h1;
						end
						else
						begin
							st_nxt = ST_RECV;
							phase_nxt = (phase_r == PH_DEV) ? PH_SUB : PH_DATA;
						end
					end
				end
				ST_SEND:
				begin
					if (scl_fall)
					begin
						if (bitcnt_r == dbc_pkg::BITS_PER_BYTE)
						begin
							st_nxt = ST_RACK;
							sda_oe_nxt = 1'b0;
						end
						else
						begin
							shift_nxt = {shift_r[6:0], 1'b0};
							sda_oe_nxt = ~shift_r[6];
							bitcnt_nxt = bitcnt_r + 4'h1;
						end
					end
				end
				ST_RACK:
				begin
					// master ack sends the next byte, nack ends the read
					if (scl_rise)
						st_nxt = sda_s ? ST_IDLE : ST_ACK;
				end
			endcase
		end
	end

	// serial slave registers
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			st_r <= ST_IDLE;
			phase_r <= PH_DEV;
			bitcnt_r <= 4'h0;
			shift_r <= 8'h00;
			ptr_r <= 8'h00;
			rw_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			phase_r <= phase_nxt;
			bitcnt_r <= bitcnt_nxt;
			shift_r <= shift_nxt;
			ptr_r <= ptr_nxt;
			rw_r <= rw_nxt;
			sda_oe_r <= sda_oe_nxt;
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	// reserved codes are stored as written; software owns their avoidance
	always_comb
	begin
		csr_nxt = csr_r;
		if (wr_en)
		begin
			unique case (ptr_r)
				dbc_pkg::OFS_OUT_CLOCK_SOURCE:
				begin
					csr_nxt.out_range = shift_r[dbc_pkg::POS_OUT_RANGE +: 3];
					csr_nxt.pixel_clock_source_select = shift_r[dbc_pkg::POS_SRC_SEL];
				end
				dbc_pkg::OFS_OUT_CLOCK_SCALE:
				begin
					csr_nxt.div_code = shift_r[dbc_pkg::POS_DIV_CODE +: 5];
					csr_nxt.ref_input_scale_code = shift_r[dbc_pkg::POS_MULT_CODE +: 2];
				end
				dbc_pkg::OFS_SYNTH_LOOP:
					csr_nxt.pll_enable = shift_r[dbc_pkg::POS_PLL_EN];
				dbc_pkg::OFS_RX_ARRANGE:
				begin
					csr_nxt.pixel_split_lr = shift_r[dbc_pkg::POS_SPLIT];
					csr_nxt.channel_mode = shift_r[dbc_pkg::POS_CH_MODE +: 2];
					csr_nxt.rx_a_lane_count = shift_r[dbc_pkg::POS_LANE_A +: 2];
					csr_nxt.rx_b_lane_count = shift_r[dbc_pkg::POS_LANE_B +: 2];
					csr_nxt.leader_error_strict = shift_r[dbc_pkg::POS_STRICT];
				end
				dbc_pkg::OFS_RX_EQUALIZE:
				begin
					csr_nxt.rx_a_data_equalize = shift_r[dbc_pkg::POS_EQ_A_DATA +: 2];
					csr_nxt.rx_b_data_equalize = shift_r[dbc_pkg::POS_EQ_B_DATA +: 2];
					csr_nxt.rx_a_clock_equalize = shift_r[dbc_pkg::POS_EQ_A_CLK +: 2];
					csr_nxt.rx_b_clock_equalize = shift_r[dbc_pkg::POS_EQ_B_CLK +: 2];
				end
				dbc_pkg::OFS_RX_A_BAND:
					csr_nxt.rx_a_clock_band = shift_r;
				dbc_pkg::OFS_RX_B_BAND:
					csr_nxt.rx_b_clock_band = shift_r;
				default:
					csr_nxt = csr_r;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			csr_r.out_range <= dbc_pkg::RST_OUT_RANGE;
			csr_r.pixel_clock_source_select <= 1'b0;
			csr_r.div_code <= dbc_pkg::RST_DIV_CODE;
			csr_r.ref_input_scale_code <= dbc_pkg::RST_MULT_CODE;
			csr_r.pll_enable <= 1'b0;
			csr_r.pixel_split_lr <= 1'b0;
			csr_r.channel_mode <= dbc_pkg::RST_CH_MODE;
			csr_r.rx_a_lane_count <= dbc_pkg::RST_LANES;
			csr_r.rx_b_lane_count <= dbc_pkg::RST_LANES;
			csr_r.leader_error_strict <= 1'b0;
			csr_r.rx_a_data_equalize <= dbc_pkg::RST_EQ;
			csr_r.rx_b_data_equalize <= dbc_pkg::RST_EQ;
			csr_r.rx_a_clock_equalize <= dbc_pkg::RST_EQ;
			csr_r.rx_b_clock_equalize <= dbc_pkg::RST_EQ;
			csr_r.rx_a_clock_band <= dbc_pkg::RST_BAND;
			csr_r.rx_b_clock_band <= dbc_pkg::RST_BAND;
		end
		else
			csr_r <= csr_nxt;
	end

	// ------------------------------------------------------------
	// decoded controls toward the clock synthesizer and receiver
	// ------------------------------------------------------------
	logic [5:0] div_ratio_r;
	logic [2:0] mult_factor_r;
	logic [7:0] lane_en_r;

	// one cycle behind the field registers, which is harmless for static settings
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			div_ratio_r <= 6'h01;
			mult_factor_r <= 3'h1;
			lane_en_r <= 8'h11;
		end
		else
		begin
			div_ratio_r <= csr_r.pixel_clock_source_select ?
				({1'b0, csr_r.div_code} + 6'h01) : 6'h01;
			mult_factor_r <= csr_r.pixel_clock_source_select ?
				3'h1 : ({1'b0, csr_r.ref_input_scale_code} + 3'h1);
			lane_en_r[3:0] <= 4'(dbc_pkg::FULL_LANE_MASK >> csr_r.rx_a_lane_count);
			lane_en_r[7:4] <= 4'(dbc_pkg::FULL_LANE_MASK >> csr_r.rx_b_lane_count);
		end
	end

	// outputs straight from flops; the data pin value is tied low
	assign o_sda_out = 1'b0;
	assign o_sda_oe = sda_oe_r;
	assign o_cfg = csr_r;
	assign o_div_ratio = div_ratio_r;
	assign o_mult_factor = mult_factor_r;
	assign o_rx_lane_en = lane_en_r;
endmodule

/* File: verif/dbc_cfg_regs_assertions.sv */
// Purpose: port checks of the clock and receiver config bank
// Assumes: one clock domain, async active-high reset
// Notes: bound below to every bank instance
`timescale 1ns/1ps
module dbc_cfg_chk
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_addr_sel,
	input wire logic o_sda_out,
	input wire logic o_sda_oe,
	input wire dbc_pkg::dbc_csr_t o_cfg,
	input wire logic [5:0] o_div_ratio,
	input wire logic [2:0] o_mult_factor,
	input wire logic [7:0] o_rx_lane_en
);
	// reset image of all fields
	localparam dbc_pkg::dbc_csr_t DEF = '{out_range: dbc_pkg::RST_OUT_RANGE,
		channel_mode: dbc_pkg::RST_CH_MODE, rx_a_lane_count: dbc_pkg::RST_LANES,
		rx_b_lane_count: dbc_pkg::RST_LANES, default: '0};
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	chk_div_ratio: assert property (
		o_div_ratio == ($past(o_cfg.pixel_clock_source_select) ?
		{1'b0, $past(o_cfg.div_code)} + 6'h01 : 6'h01))
		else $error("divide ratio wrong");
	chk_mult_factor: assert property (
		o_mult_factor == ($past(o_cfg.pixel_clock_source_select) ? 3'h1 :
		{1'b0, $past(o_cfg.ref_input_scale_code)} + 3'h1))
		else $error("multiplier wrong");
	chk_lane_a_mask: assert property (
		o_rx_lane_en[3:0] == (4'hF >> $past(o_cfg.rx_a_lane_count)))
		else $error("lane mask a wrong");
	chk_lane_b_mask: assert property (
		o_rx_lane_en[7:4] == (4'hF >> $past(o_cfg.rx_b_lane_count)))
		else $error("lane mask b wrong");
	chk_reset_image: assert property (
		$fell(i_rst) |-> o_cfg == DEF && !o_sda_oe)
		else $error("reset image wrong");
	chk_store_ack: assert property (
		$changed(o_cfg) |-> !i_scl ##[0:6] o_sda_oe)
		else $error("stored byte not acknowledged");
	chk_drive_low_phase: assert property (
		$rose(o_sda_oe) |-> !i_scl)
		else $error("data driven while clock high");
	chk_drive_hold: assert property (
		o_sda_oe && i_scl |=> o_sda_oe)
		else $error("data released while clock high");
	chk_sda_value_low: assert property (
		o_sda_out == 1'b0)
		else $error("data pin value not low");
endmodule
bind dbc_cfg_regs dbc_cfg_chk u_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_scl(i_scl),
	.i_sda(i_sda), .i_addr_sel(i_addr_sel), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
	.o_cfg(o_cfg), .o_div_ratio(o_div_ratio), .o_mult_factor(o_mult_factor),
	.o_rx_lane_en(o_rx_lane_en));

/* File: verif/dbc_host_model.sv */
// Purpose: two-wire master standing in for the host processor
// Assumes: pulled-up data line, phases of ten reference clocks
// Notes: pulls data low only; a released line floats high
`timescale 1ns/1ps
module dbc_host_model
(
	input wire logic i_ref_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_low
);
	// bus idle: both lines released
	initial
	begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	task automatic wclk(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask
	// data moves mid low phase so it never looks like start or stop
	task automatic bit_io(input logic b, output logic s);
		wclk(5);
		o_sda_low <= ~b;
		wclk(5);
		o_scl <= 1'b1;
		wclk(5);
		s = i_sda;
		wclk(5);
		o_scl <= 1'b0;
	endtask
	// start, also valid as a repeated start
	task automatic start();
		wclk(5);
		o_sda_low <= 1'b0;
		wclk(5);
		o_scl <= 1'b1;
		wclk(10);
		o_sda_low <= 1'b1;
		wclk(10);
		o_scl <= 1'b0;
	endtask
	task automatic stop();
		wclk(5);
		o_sda_low <= 1'b1;
		wclk(5);
		o_scl <= 1'b1;
		wclk(10);
		o_sda_low <= 1'b0;
		wclk(10);
	endtask
	task automatic send(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask
	// last byte of a read is refused to end it
	task automatic recv(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(last, s);
	endtask
	task automatic wr(input logic [6:0] dev, input logic [7:0] sub, input logic [7:0] d[$],
		output logic ok);
		logic a;
		start();
		send({dev, 1'b0}, ok);
		if (ok)
		begin
			send(sub, a);
			ok = ok & a;
			foreach (d[i])
			begin
				send(d[i], a);
				ok = ok & a;
			end
		end
		stop();
	endtask
	task automatic rd(input logic [6:0] dev, input int n, output logic [7:0] q[$]);
		logic a;
		logic [7:0] b;
		q = {};
		start();
		send({dev, 1'b1}, a);
		for (int i = 0; i < n; i++)
		begin
			recv(i == n - 1, b);
			q.push_back(b);
		end
		stop();
	endtask
endmodule

/* File: verif/dbc_cfg_regs_tb_top.sv */
// Purpose: self-checking bench of the config bank
// Assumes: host model on the serial pins, seed fixed
// Notes: expectations come from a byte mirror of the bank
`timescale 1ns/1ps
module dbc_cfg_regs_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic addr_sel = 1'b0;
	logic scl;
	logic sda_low;
	logic sda_oe;
	wire sda;
	dbc_pkg::dbc_csr_t cfg;
	logic [5:0] div_ratio;
	logic [2:0] mult_factor;
	logic [7:0] lane_en;
	logic [7:0] exp_reg [10];
	int n_mismatch = 0;
	int samples_checked = 0;
	always #10 clk = ~clk;
	// pulled-up wire, low when either party pulls
	assign sda = ~(sda_low | sda_oe);
	dbc_cfg_regs DUT (.i_ref_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda),
		.i_addr_sel(addr_sel), .o_sda_out(), .o_sda_oe(sda_oe), .o_cfg(cfg),
		.o_div_ratio(div_ratio), .o_mult_factor(mult_factor), .o_rx_lane_en(lane_en));
	dbc_host_model host (.i_ref_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
	// ------------------------------------------------------------
	// expectation helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask
	// writable bits per offset, all else reads zero
	function automatic logic [7:0] wmask(input logic [7:0] off);
		case (off)
			8'h0A: return 8'h0F;
			8'h0B: return 8'hFB;
			8'h0D: return 8'h01;
			8'h10, 8'h11, 8'h12, 8'h13: return 8'hFF;
			default: return 8'h00;
		endcase
	endfunction
	// legal equalizer code: none, 1 dB or 2 dB, never the reserved 10
	function automatic logic [1:0] eq_pick();
		int r;
		r = $urandom_range(2);
		return (r == 2) ? 2'h3 : 2'(r);
	endfunction
	task automatic exp_reset();
		exp_reg = '{8'h0A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3E, 8'h00, 8'h00, 8'h00};
	endtask
	task automatic regwr(input logic [7:0] sub, input logic [7:0] d[$]);
		logic a;
		logic [7:0] o;
		host.wr({dbc_pkg::DEV_ADDR_HI, addr_sel}, sub, d, a);
		chk(64'(a), 64'h1, "write ack");
		foreach (d[i])
		begin
			o = sub + 8'(i);
			if (o >= 8'h0A && o <= 8'h13)
				exp_reg[o - 8'h0A] = d[i] & wmask(o);
		end
	endtask
	task automatic check_all();
		logic [7:0] none [$];
		logic [7:0] rq [$];
		dbc_pkg::dbc_csr_t c;
		regwr(8'h0A, none);
		host.rd({dbc_pkg::DEV_ADDR_HI, addr_sel}, 10, rq);
		for (int i = 0; i < 10; i++)
			chk(64'(rq[i]), 64'(exp_reg[i]), "readback");
		// fields in package order
		c = {exp_reg[0][3:0], exp_reg[1][7:3], exp_reg[1][1:0], exp_reg[3][0], exp_reg[6],
			exp_reg[7], exp_reg[8], exp_reg[9]};
		chk(64'(cfg), 64'(c), "fields");
		chk(64'(div_ratio), c.pixel_clock_source_select ? 64'(c.div_code) + 1 : 1, "div");
		chk(64'(mult_factor), c.pixel_clock_source_select ? 1 :
			64'(c.ref_input_scale_code) + 1, "mult");
		chk(64'(lane_en[3:0]), 64'(4'hF >> c.rx_a_lane_count), "lanes a");
		chk(64'(lane_en[7:4]), 64'(4'hF >> c.rx_b_lane_count), "lanes b");
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		logic [7:0] d [$];
		logic a;
		logic src;
		logic [4:0] dv;
		void'($urandom(52));
		exp_reset();
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		check_all();
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk);
			addr_sel <= 1'($urandom);
			// let the strap land before the host builds its address byte
			@(posedge clk);
			src = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'($urandom);
			dv = (i == 0) ? 5'h18 : 5'($urandom_range(24));
			// loop off before clock settings change
			d = {8'h00};
			regwr(dbc_pkg::OFS_SYNTH_LOOP, d);
			d = {{4'h0, 3'($urandom_range(5)), src},
				src ? {dv, 3'h0} : {6'h00, (i == 1) ? 2'h3 : 2'($urandom)}};
			regwr(dbc_pkg::OFS_OUT_CLOCK_SOURCE, d);
			// sources, soft reset and lock wait lie outside this bank
			d = {8'h01};
			regwr(dbc_pkg::OFS_SYNTH_LOOP, d);
			// every mode and lane code, legal equalizers and bands
			d = {{1'($urandom), 2'(i % 3), 2'(i % 4), 2'(3 - i % 4), 1'($urandom)},
				{eq_pick(), eq_pick(), eq_pick(), eq_pick()},
				8'($urandom_range(100, 8)), 8'($urandom_range(100, 8))};
			regwr(dbc_pkg::OFS_RX_ARRANGE, d);
			check_all();
		end
		// the other strap address is refused and changes nothing
		d = {8'hFF};
		host.wr({dbc_pkg::DEV_ADDR_HI, ~addr_sel}, dbc_pkg::OFS_RX_B_BAND, d, a);
		chk(64'(a), 64'h0, "foreign address");
		// unmapped byte dropped, enable keeps only bit 0
		d = {8'hFF, 8'hFF};
		regwr(8'h0C, d);
		check_all();
		@(posedge clk);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		exp_reset();
		repeat (3) @(posedge clk);
		check_all();
		results();
	end
	// watchdog at 80k clocks, well beyond the roughly 53k clocks of traffic
	initial
	begin
		#1600000;
		n_mismatch++;
		results();
	end
endmodule
